// ### cac_map.vh
/*
  register map, field positions, reset values for the counter array control/status block.
  assumes an 8-bit special function register bus with address, write and read strobes.
*/
// Notes on behaviour
// [RL1] overflow flag sets when the counter wraps from FFFF to 0000
// [RL2] set overflow flag with overflow interrupt enable raises the array interrupt
// [RL3] overflow and module flags are sticky; only software clears them
// [RL4] run control 0 stops the counter, 1 lets it run
// [RL5] control bits 5:3 read zero and ignore writes
// [RL6] module flags in bits 2..0 set on that module's match or capture
// [RL7] enabled module flag requests the shared array interrupt
// [RL8] control register decoded at D8, bit access, resets to all zeros
// [RL9] mode register: idle, watchdog enable, lock, ro bit4, clock select 3:1, ovf enable
// [RL10] mode register resets with watchdog enable set, all else zero
// [RL11] idle suspend 1 stops the array during cpu idle, 0 keeps it running
// [RL12] writing 0 clears a flag; a same-cycle hardware set wins
`ifndef CAC_MAP_VH
`define CAC_MAP_VH
`define CAC_ADDR_CONTROL 8'hD8
`define CAC_ADDR_MODE 8'hD9
`define CAC_CTL_OVF 7
`define CAC_CTL_RUN 6
`define CAC_CTL_MOD2 2
`define CAC_CTL_MOD0 0
`define CAC_MD_IDLE 7
`define CAC_MD_WDE 6
`define CAC_MD_WATCHDOG_LOCK 5
`define CAC_MD_CPS_HI 3
`define CAC_MD_CPS_LO 1
`define CAC_MD_OVFIE 0
`define CAC_CTL_RESET 8'h00
`define CAC_MD_RESET 8'h40
`define CAC_CTL_WMASK 8'hC7
`define CAC_MD_WMASK 8'hEF
`define CAC_CNT_MAX 16'hFFFF
`define CAC_CNT_ZERO 16'h0000
`endif

// ### cac_control_status.v
/*
  control and mode registers of the 16-bit counter array with run gating, sticky flags
  and the shared interrupt request. assumes a synchronous sfr bus: one-cycle write strobe,
  byte write with a per-bit enable mask for bit access, combinational-free registered read.
*/
`timescale 1ns/1ps
`include "cac_map.vh"
module cac_control_status #(
  parameter NUM_MODULES = 3
) (
  // clock and reset
  input wire sys_clk,
  input wire rst,
  // special function register bus
  input wire [7:0] sfr_addr,
  input wire sfr_wr,
  input wire [7:0] sfr_wdata,
  input wire [7:0] sfr_wbit_mask,
  input wire sfr_rd,
  output reg [7:0] sfr_rdata,
  // counter array events
  input wire counter_tick,
  input wire [15:0] counter_value,
  input wire [NUM_MODULES-1:0] module_event,
  input wire [NUM_MODULES-1:0] module_irq_enable,
  input wire cpu_idle,
  // control outputs
  output reg counter_run,
  output reg [2:0] clock_select,
  output reg watchdog_enable,
  output reg watchdog_lock,
  output reg counter_array_irq
);

  // ----------------------------------------
  // register state
  // ----------------------------------------
  reg overflow_flag;
  reg run_control;
  reg [NUM_MODULES-1:0] module_event_flag;
  reg [7:0] array_mode;
  wire wr_ctl = sfr_wr && (sfr_addr == `CAC_ADDR_CONTROL);
  wire wr_md = sfr_wr && (sfr_addr == `CAC_ADDR_MODE);
  // bit access: only bits in the mask are written
  wire [7:0] ctl_cur = {overflow_flag, run_control, 3'h0, module_event_flag};
  wire [7:0] ctl_wr = (ctl_cur & ~sfr_wbit_mask) | (sfr_wdata & sfr_wbit_mask);
  wire [7:0] md_wr = (array_mode & ~sfr_wbit_mask) | (sfr_wdata & sfr_wbit_mask);
  // [RL1] wrap detection: counter at max when it ticks
  wire wrap = counter_tick && (counter_value == `CAC_CNT_MAX);
  // [RL11] idle suspend gating
  wire suspended = array_mode[`CAC_MD_IDLE] && cpu_idle;

  // ----------------------------------------
  // control register
  // ----------------------------------------
  always @(posedge sys_clk) begin
    // [RL8] control resets to zero
    if (rst) begin
      overflow_flag <= 1'b0;
      run_control <= 1'b0;
    end else begin
      // [RL4] run control written by software
      if (wr_ctl)
        run_control <= ctl_wr[`CAC_CTL_RUN];
      // [RL3] sticky; [RL12] set wins over clear
      if (wrap)
        overflow_flag <= 1'b1;
      else if (wr_ctl)
        overflow_flag <= ctl_wr[`CAC_CTL_OVF];
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < NUM_MODULES; gi = gi + 1) begin : g_mod
      always @(posedge sys_clk) begin
        if (rst) begin
          module_event_flag[gi] <= 1'b0;
        // [RL6] module set; [RL12] set beats clear
        end else if (module_event[gi]) begin
          module_event_flag[gi] <= 1'b1;
        end else if (wr_ctl) begin
          module_event_flag[gi] <= ctl_wr[`CAC_CTL_MOD0 + gi];
        end
      end
    end
  endgenerate

  // ----------------------------------------
  // mode register
  // ----------------------------------------
  always @(posedge sys_clk) begin
    // [RL10] watchdog enabled out of reset
    if (rst) begin
      array_mode <= `CAC_MD_RESET;
    // [RL9] field layout, bit 4 read only
    end else if (wr_md) begin
      array_mode <= md_wr & `CAC_MD_WMASK;
    end
  end

  // ----------------------------------------
  // outputs and readback
  // ----------------------------------------
  always @(posedge sys_clk) begin
    if (rst) begin
      sfr_rdata <= 8'h00;
      counter_run <= 1'b0;
      clock_select <= 3'h0;
      watchdog_enable <= 1'b0;
      watchdog_lock <= 1'b0;
      counter_array_irq <= 1'b0;
    end else begin
      // [RL5] unused bits read zero
      if (sfr_rd && sfr_addr == `CAC_ADDR_CONTROL)
        sfr_rdata <= ctl_cur & `CAC_CTL_WMASK;
      else if (sfr_rd && sfr_addr == `CAC_ADDR_MODE)
        sfr_rdata <= array_mode;
      else if (sfr_rd)
        sfr_rdata <= 8'h00;
      // [RL4] gate counting; idle can suspend it
      counter_run <= run_control && !suspended;
      clock_select <= array_mode[`CAC_MD_CPS_HI:`CAC_MD_CPS_LO];
      watchdog_enable <= array_mode[`CAC_MD_WDE];
      watchdog_lock <= array_mode[`CAC_MD_WATCHDOG_LOCK];
      // [RL2] overflow interrupt; [RL7] module interrupts
      counter_array_irq <= (overflow_flag && array_mode[`CAC_MD_OVFIE]) ||
                           (|(module_event_flag & module_irq_enable));
    end
  end

endmodule // cac_control_status

// ### cac_control_status_asserts.sv
/* checker for the counter array control block; sees only the block's ports, bound below */
`timescale 1ns/1ps
module cac_sva #(parameter NUM_MODULES = 3) (
  // clock, reset and bus
  input wire sys_clk, input wire rst, input wire [7:0] sfr_addr, input wire sfr_wr,
  input wire [7:0] sfr_wdata, input wire [7:0] sfr_wbit_mask, input wire sfr_rd, input wire [7:0] sfr_rdata,
  // events and outputs
  input wire [NUM_MODULES-1:0] module_event, input wire [NUM_MODULES-1:0] module_irq_enable,
  input wire cpu_idle, input wire counter_run, input wire [2:0] clock_select,
  input wire watchdog_enable, input wire counter_array_irq
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  sequence s_run_wr;
    sfr_wr && sfr_addr == 8'hD8 && sfr_wbit_mask[6] ##1 !cpu_idle;
  endsequence
  a_run_gate: assert property (s_run_wr |=> counter_run == $past(sfr_wdata[6], 2)) else $error("run late");
  a_irq_module: assert property (|(module_event & module_irq_enable) ##1 $stable(module_irq_enable)
    |=> counter_array_irq) else $error("no module irq");
  a_irq_sticky: assert property (counter_array_irq && !$past(sfr_wr) && $stable(module_irq_enable)
    |=> counter_array_irq) else $error("irq dropped");
  a_clock_sel: assert property (sfr_wr && sfr_addr == 8'hD9 && sfr_wbit_mask == 8'hFF
    |=> ##1 clock_select == $past(sfr_wdata[3:1], 2)) else $error("clock select");
  a_ctl_unused: assert property (sfr_rd && sfr_addr == 8'hD8 |=> sfr_rdata[5:3] == 3'h0) else $error("bits 5:3");
  a_mode_bit4: assert property (sfr_rd && sfr_addr == 8'hD9 |=> !sfr_rdata[4]) else $error("mode bit 4");
  a_wd_reset: assert property ($fell(rst) |-> ##1 watchdog_enable) else $error("watchdog off");
  a_ctl_reset: assert property ($fell(rst) |-> !counter_run && !counter_array_irq) else $error("reset");
endmodule // cac_sva
bind cac_control_status cac_sva #(.NUM_MODULES(NUM_MODULES)) u_sva (.*);

// ### test_cac_control_status.sv
/* bench for the counter array control block; drives every port directly, no partner */
`timescale 1ns/1ps
module test_cac_control_status;
  reg sys_clk = 0, rst = 1, sfr_wr = 0, sfr_rd = 0, counter_tick = 0, cpu_idle = 0;
  reg [7:0] sfr_addr = 0, sfr_wdata = 0, sfr_wbit_mask = 0;
  reg [15:0] counter_value = 0;
  reg [2:0] module_event = 0, module_irq_enable = 0;
  wire [7:0] sfr_rdata;
  wire [2:0] clock_select;
  wire counter_run, watchdog_enable, watchdog_lock, counter_array_irq;
  integer error_cnt = 0, checked = 0, cyc = 0;
  always #2.5 sys_clk = ~sys_clk;
  cac_control_status i_dut (.*);
  task ck(input string n, input [7:0] v, input [7:0] e);
    checked++;
    if (v !== e) begin
      error_cnt++;
      $display("wrong value %s exp %h seen %h", n, e, v);
    end
  endtask
  task wr(input [7:0] a, input [7:0] d, input [7:0] m, input [2:0] ev);
    @(posedge sys_clk) #1;
    {sfr_addr, sfr_wdata, sfr_wbit_mask, module_event, sfr_wr} = {a, d, m, ev, 1'b1};
    @(posedge sys_clk) #1;
    {module_event, sfr_wr} = 4'h0;
  endtask
  task rd(input [7:0] a, input [7:0] e);
    @(posedge sys_clk) #1;
    {sfr_addr, sfr_rd} = {a, 1'b1};
    @(posedge sys_clk) #1;
    sfr_rd = 0;
    ck("sfr_rdata", sfr_rdata, e);
  endtask
  task wrap_up;
    $display("errors %0d checks %0d", error_cnt, checked);
    if (error_cnt == 0 && checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // the whole run needs well under 200 cycles
  always @(posedge sys_clk) if (++cyc == 2000) begin
    error_cnt++;
    wrap_up;
  end
  initial begin
    repeat (4) @(posedge sys_clk);
    #1 rst = 0;
    rd(8'hD8, 8'h00);
    rd(8'hD9, 8'h40);
    ck("watchdog_enable", watchdog_enable, 8'h01);
    ck("watchdog_lock", watchdog_lock, 8'h00);
    rd(8'h55, 8'h00);
    wr(8'hD8, 8'hFF, 8'hFF, 0);
    rd(8'hD8, 8'hC7);
    module_irq_enable = 3'h2;
    wr(8'hD8, 8'h00, 8'hFF, 3'h2);
    rd(8'hD8, 8'h02);
    ck("irq", counter_array_irq, 1);
    wr(8'hD8, 8'h00, 8'h02, 0);
    rd(8'hD8, 8'h00);
    ck("irq", counter_array_irq, 0);
    wr(8'hD9, 8'hFF, 8'hFF, 0);
    rd(8'hD9, 8'hEF);
    ck("watchdog_lock", watchdog_lock, 8'h01);
    ck("clock_select", clock_select, 7);
    {counter_value, counter_tick} = {16'hFFFE, 1'b1};
    rd(8'hD8, 8'h00);
    counter_value = 16'hFFFF;
    rd(8'hD8, 8'h80);
    counter_tick = 0;
    ck("irq", counter_array_irq, 1);
    repeat (5) @(posedge sys_clk);
    rd(8'hD8, 8'h80);
    cpu_idle = 1;
    wr(8'hD8, 8'h40, 8'h40, 0);
    repeat (2) @(posedge sys_clk);
    #1 ck("counter_run", counter_run, 0);
    cpu_idle = 0;
    repeat (2) @(posedge sys_clk);
    #1 ck("counter_run", counter_run, 1);
    // mid-run reset must bring both registers back to their reset values
    rst = 1;
    repeat (2) @(posedge sys_clk);
    #1 rst = 0;
    rd(8'hD8, 8'h00);
    rd(8'hD9, 8'h40);
    ck("watchdog_enable", watchdog_enable, 8'h01);
    ck("counter_run", counter_run, 8'h00);
    wrap_up;
  end
endmodule // test_cac_control_status
